// ==== rtl/iei_pkg.sv ====
// iei_pkg: constants for the incremental encoder input block
// assumes a single 250 MHz clock; no software register map
package iei_pkg;
    // ---------------------------------------------------------------
    // clock and timing
    // ---------------------------------------------------------------
    localparam int CLK_MHZ = 250;               // reference clock rate
    localparam int MIN_EDGE_NS = 250;           // least spacing of counting edges
    localparam int REF_SAFE_NS = 100;           // reference mark safety interval
    localparam int MAX_FREQ_KHZ = 500;          // highest quadrature frequency
    // cycles between counting edges (shortest spacing, rounded down)
    localparam int MIN_EDGE_CYC = (MIN_EDGE_NS * CLK_MHZ) / 1000;
    // cycles the reference level must hold before it is believed
    localparam int REF_QUAL_CYC = (REF_SAFE_NS * CLK_MHZ + 999) / 1000;
    // ---------------------------------------------------------------
    // sizes
    // ---------------------------------------------------------------
    localparam int AXES_BASE = 5;               // base fit
    localparam int AXES_MAX = 8;                // optional fit
    localparam int POS_W = 32;                  // position counter width
    localparam int RATE_W = 16;                 // sampling period field width
    localparam int QUAL_W = 8;                  // reference qualifier counter width
    localparam logic [RATE_W-1:0] RATE_RST = 16'h00fa; // default sample period, cycles
    localparam logic [POS_W-1:0] POS_RST = 32'h0000_0000; // counter reset value
    localparam logic [QUAL_W-1:0] QUAL_TGT = QUAL_W'(REF_QUAL_CYC); // qualify length
    localparam logic [1:0] SYNC_RST = 2'h0;     // synchroniser reset
endpackage

// ==== rtl/iei_axis.sv ====
// iei_axis: one quadrature channel with reference-mark latch
// assumes inputs already past the line receiver, synchronous to the clock
`timescale 1ns/1ns
module iei_axis
    import iei_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic trk_a,
    input wire logic trk_b,
    input wire logic trk_r,
    input wire logic invert,
    output logic [POS_W-1:0] pos,
    output logic [POS_W-1:0] ref_pos,
    output logic ref_hit
);
    // ---------------------------------------------------------------
    // synchronisers
    // ---------------------------------------------------------------
    logic [1:0] sa_r, sb_r, sr_r;      // two-stage sync chains
    logic qa_r, qb_r;                  // previous synchronised phase
    logic [POS_W-1:0] pos_r, pos_nxt;  // position counter
    logic [POS_W-1:0] refp_r, refp_nxt;// latched position at mark
    logic hit_r, hit_nxt;              // one-cycle mark strobe
    logic [QUAL_W-1:0] q_r, q_nxt;     // reference level qualifier
    logic armed_r, armed_nxt;          // set once a mark is taken, cleared on drop
    logic up, dn;                      // decoded step this cycle
    logic ref_ok;                      // qualified mark condition

    // stage two reads stage one only
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sa_r <= SYNC_RST;
            sb_r <= SYNC_RST;
            sr_r <= SYNC_RST;
            qa_r <= 1'b0;
            qb_r <= 1'b0;
        end
        else
        begin
            sa_r <= {sa_r[0], trk_a};
            sb_r <= {sb_r[0], trk_b};
            sr_r <= {sr_r[0], trk_r};
            qa_r <= sa_r[1];
            qb_r <= sb_r[1];
        end
    end

    // ---------------------------------------------------------------
    // decode and count
    // ---------------------------------------------------------------
    // every edge of either track is a step; direction from phase order,
    // evaluated fresh each edge so a reversal needs no dwell
    always_comb
    begin
        up = 1'b0;
        dn = 1'b0;
        if ((sa_r[1] ^ qa_r) || (sb_r[1] ^ qb_r))
        begin
            // forward when new a differs from old b
            if (sa_r[1] ^ qb_r)
                up = 1'b1;
            else
                dn = 1'b1;
        end
        // inversion in logic, never by swapping tracks
        if (invert)
        begin
            {up, dn} = {dn, up};
        end
        pos_nxt = pos_r;
        if (up)
            pos_nxt = pos_r + 1'b1;
        else if (dn)
            pos_nxt = pos_r - 1'b1;
    end

    // ---------------------------------------------------------------
    // reference qualification
    // ---------------------------------------------------------------
    // a mark counts only after the level stands for the safety interval;
    // a glitch shorter than that is discarded
    always_comb
    begin
        q_nxt = sr_r[1] ? ((q_r == QUAL_TGT) ? q_r : q_r + 1'b1) : '0;
        ref_ok = (q_r == QUAL_TGT) && !armed_r;
        armed_nxt = sr_r[1] ? (armed_r | ref_ok) : 1'b0;
        hit_nxt = ref_ok;
        refp_nxt = ref_ok ? pos_r : refp_r;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pos_r <= POS_RST;
            refp_r <= POS_RST;
            hit_r <= 1'b0;
            q_r <= '0;
            armed_r <= 1'b0;
        end
        else
        begin
            pos_r <= pos_nxt;
            refp_r <= refp_nxt;
            hit_r <= hit_nxt;
            q_r <= q_nxt;
            armed_r <= armed_nxt;
        end
    end

    assign pos = pos_r;
    assign ref_pos = refp_r;
    assign ref_hit = hit_r;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    step_one_a: assert property (@(posedge clk) disable iff (rst)
        (sa_r[1] != qa_r) |=> (pos_r != $past(pos_r)))
        else $error("edge on track a not counted");
    // track b edges must count as well, or the rate halves at speed
    step_two_a: assert property (@(posedge clk) disable iff (rst)
        (sb_r[1] != qb_r) |=> (pos_r != $past(pos_r)))
        else $error("edge on track b not counted");
    step_size_a: assert property (@(posedge clk) disable iff (rst)
        (pos_r == $past(pos_r)) || (pos_r == $past(pos_r) + 1'b1) || (pos_r == $past(pos_r) - 1'b1))
        else $error("position moved by more than one");
    ref_latch_a: assert property (@(posedge clk) disable iff (rst)
        hit_r |-> (refp_r == $past(pos_r)))
        else $error("mark did not latch position");
    ref_qual_a: assert property (@(posedge clk) disable iff (rst)
        hit_r |-> $past(sr_r[1], 2))
        else $error("mark taken without level");
endmodule

// ==== rtl/iei_top.sv ====
// iei_top: incremental encoder inputs for a multi-axis servo card
// assumes synchronous pin inputs after the line receivers, one 250 MHz clock
`timescale 1ns/1ns
module iei_top
    import iei_pkg::*;
#(
    parameter int AXES = iei_pkg::AXES_BASE  // 5 base, up to 8 with option
)
(
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic [AXES-1:0] ENC_A,          // receiver output, track a
    input wire logic [AXES-1:0] ENC_B,          // receiver output, track b
    input wire logic [AXES-1:0] ENC_R,          // receiver output, reference
    input wire logic [AXES-1:0] ENC_FAULT,      // encoder fault line, unused
    input wire logic [AXES-1:0] DIR_INVERT,     // software count inversion
    input wire logic [iei_pkg::RATE_W-1:0] SAMPLING_RATE_PARAMETER, // period in cycles
    output logic [AXES*iei_pkg::POS_W-1:0] POS_SAMPLE, // sampled positions
    output logic [AXES*iei_pkg::POS_W-1:0] REF_POS,    // position at last mark
    output logic [AXES-1:0] REF_SEEN,           // sticky mark seen per axis
    output logic SAMPLE_TICK                    // one-cycle servo sample strobe
);
    import iei_pkg::*;

    // ---------------------------------------------------------------
    // per-axis channels
    // ---------------------------------------------------------------
    logic [AXES*POS_W-1:0] pos_w;      // live counters
    logic [AXES-1:0] hit_w;            // mark strobes
    logic [AXES-1:0] seen_r, seen_nxt; // sticky marks
    // fault line is not evaluated; the shaper signals faults by
    // floating its outputs, which the line receiver must catch
    logic [AXES-1:0] fault_unused;
    assign fault_unused = ENC_FAULT;

    // one channel per axis; the receivers give single-ended levels
    genvar g;
    generate
        for (g = 0; g < AXES; g++)
        begin : g_axis
            iei_axis u_axis (
                .clk(REF_CLK),
                .rst(RST),
                .trk_a(ENC_A[g]),
                .trk_b(ENC_B[g]),
                .trk_r(ENC_R[g]),
                .invert(DIR_INVERT[g]),
                .pos(pos_w[g*POS_W +: POS_W]),
                .ref_pos(REF_POS[g*POS_W +: POS_W]),
                .ref_hit(hit_w[g])
            );
        end
    endgenerate

    // ---------------------------------------------------------------
    // sampling period divider
    // ---------------------------------------------------------------
    logic [RATE_W-1:0] div_r, div_nxt;        // cycles until next sample
    logic tick_r, tick_nxt;                   // sample strobe
    logic [AXES*POS_W-1:0] samp_r, samp_nxt;  // held positions

    // a zero period is read as one so the loop never stalls
    always_comb
    begin
        tick_nxt = 1'b0;
        div_nxt = div_r - 1'b1;
        if (div_r == '0 || div_r == RATE_W'(1))
        begin
            tick_nxt = 1'b1;
            div_nxt = (SAMPLING_RATE_PARAMETER == '0) ? RATE_W'(1) : SAMPLING_RATE_PARAMETER;
        end
        samp_nxt = tick_nxt ? pos_w : samp_r;
        seen_nxt = seen_r | hit_w;
    end

    always_ff @(posedge REF_CLK or posedge RST)
    begin
        if (RST)
        begin
            div_r <= RATE_RST;
            tick_r <= 1'b0;
            samp_r <= '0;
            seen_r <= '0;
        end
        else
        begin
            div_r <= div_nxt;
            tick_r <= tick_nxt;
            samp_r <= samp_nxt;
            seen_r <= seen_nxt;
        end
    end

    assign POS_SAMPLE = samp_r;
    assign SAMPLE_TICK = tick_r;
    assign REF_SEEN = seen_r;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    // the 250 ns edge spacing leaves 62 cycles, far above the sync delay
    sample_hold_a: assert property (@(posedge REF_CLK) disable iff (RST)
        !tick_r |-> (samp_r == $past(samp_r)))
        else $error("sample changed without tick");
    sample_take_a: assert property (@(posedge REF_CLK) disable iff (RST)
        tick_r |-> (samp_r == $past(pos_w)))
        else $error("sample missed live position");
    seen_stick_a: assert property (@(posedge REF_CLK) disable iff (RST)
        $past(seen_r) != '0 |-> ((seen_r & $past(seen_r)) == $past(seen_r)))
        else $error("mark flag lost");
    // each strobe reloads the divider from the period seen one cycle before
    tick_reload_a: assert property (@(posedge REF_CLK) disable iff (RST)
        tick_r |-> (div_r == (($past(SAMPLING_RATE_PARAMETER) == '0) ? RATE_W'(1)
                                                                       : $past(SAMPLING_RATE_PARAMETER))))
        else $error("sample period not reloaded");
endmodule

// ==== testbench/iei_enc_model.sv ====
// iei_enc_model: behavioural quadrature encoder, one per axis
// assumes the bench calls its tasks; levels move 1 ns after a clock edge
`timescale 1ns/1ns
module iei_enc_model
#(
    parameter int AXES = 8
)
(
    input wire logic clk,
    output logic [AXES-1:0] enc_a,
    output logic [AXES-1:0] enc_b,
    output logic [AXES-1:0] enc_r
);
    // -----------------------------------------
    // phase state, tracks hold their level when idle
    // -----------------------------------------
    logic [1:0] ph [AXES]; // quadrature phase per axis
    initial
    begin
        for (int i = 0; i < AXES; i++) ph[i] = 2'h0;
        enc_r = '0;
    end
    // healthy shaper: outputs always driven, never floated
    // phase to levels: track a leads track b when counting up
    always_comb
    begin
        for (int i = 0; i < AXES; i++)
        begin
            enc_a[i] = (ph[i] == 2'h1) || (ph[i] == 2'h2);
            enc_b[i] = ph[i][1];
        end
    end
    // one edge, then gap cycles; 64 cycles keeps 250 ns, 0 only on reversal
    task automatic step(input int ax, input logic up, input int gap);
        @(posedge clk);
        #1 ph[ax] = up ? ph[ax] + 2'h1 : ph[ax] - 2'h1;
        repeat (gap) @(posedge clk);
    endtask
    // reference pulse, 25 idle cycles (100 ns) kept on both sides
    task automatic mark(input int ax, input int len);
        repeat (25) @(posedge clk);
        #1 enc_r[ax] = 1'b1;
        repeat (len) @(posedge clk);
        #1 enc_r[ax] = 1'b0;
        repeat (25) @(posedge clk);
    endtask
endmodule

// ==== testbench/tb_incremental_encoder_input.sv ====
// tb_incremental_encoder_input: self-checking bench for iei_top, 8 axes
// assumes iei_pkg and the encoder model are compiled first
`timescale 1ns/1ns
module tb_incremental_encoder_input;
    import iei_pkg::*;
    // -----------------------------------------
    // clock, reset and pins
    // -----------------------------------------
    logic REF_CLK = 1'b0;
    logic RST = 1'b1;
    logic [7:0] enc_a, enc_b, enc_r;
    logic [7:0] fault = '0; // fault lines, toggled to prove they do nothing
    logic [7:0] inv = '0; // per-axis count inversion
    logic [15:0] rate = 16'h0064; // sample period, 100 cycles
    logic [255:0] pos_s, ref_p;
    logic [7:0] seen;
    logic tick;
    int bad_count = 0;
    int compares = 0;
    always #2 REF_CLK = ~REF_CLK; // 250 MHz
    iei_enc_model #(.AXES(8)) enc (.clk(REF_CLK), .enc_a(enc_a), .enc_b(enc_b), .enc_r(enc_r));
    iei_top #(.AXES(8)) dut (.REF_CLK(REF_CLK), .RST(RST), .ENC_A(enc_a), .ENC_B(enc_b),
        .ENC_R(enc_r), .ENC_FAULT(fault), .DIR_INVERT(inv), .SAMPLING_RATE_PARAMETER(rate),
        .POS_SAMPLE(pos_s), .REF_POS(ref_p), .REF_SEEN(seen), .SAMPLE_TICK(tick));
    // -----------------------------------------
    // shared tasks
    // -----------------------------------------
    task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // bounded wait for the strobe, then one edge so the sample has landed
    task automatic wait_tick(output int n);
        n = 0;
        while (tick !== 1'b1 && n < 2000)
        begin
            @(posedge REF_CLK);
            #1 n++;
        end
        if (n >= 2000) bad_count++;
        @(posedge REF_CLK);
        #1;
    endtask
    task automatic pos_is(input int ax, input logic [31:0] exp);
        int n;
        wait_tick(n);
        check("pos", pos_s[ax*32 +: 32], exp);
    endtask
    task automatic steps(input int ax, input int k);
        for (int i = 0; i < k; i++) enc.step(ax, 1'b1, 64);
    endtask
    // -----------------------------------------
    // scenarios
    // -----------------------------------------
    task automatic t_count;
        steps(0, 4);
        pos_is(0, 32'h0000_0004);
        steps(7, 2);
        pos_is(7, 32'h0000_0002);
    endtask
    task automatic t_reverse;
        enc.step(1, 1'b1, 64);
        enc.step(1, 1'b1, 0);
        enc.step(1, 1'b0, 64);
        enc.step(1, 1'b0, 64);
        enc.step(1, 1'b0, 64);
        pos_is(1, 32'hffff_ffff);
    endtask
    task automatic t_invert;
        inv[2] = 1'b1;
        steps(2, 4);
        pos_is(2, 32'hffff_fffc);
    endtask
    task automatic t_fault;
        fault = 8'hff;
        steps(3, 3);
        fault[3] = 1'b0;
        pos_is(3, 32'h0000_0003);
    endtask
    task automatic t_mark;
        steps(4, 3);
        enc.mark(4, 10);
        check("seen short", {31'h0, seen[4]}, 32'h0);
        enc.mark(4, 40);
        check("seen", {31'h0, seen[4]}, 32'h1);
        check("ref pos", ref_p[4*32 +: 32], 32'h0000_0003);
    endtask
    task automatic t_rate;
        int n;
        wait_tick(n);
        wait_tick(n);
        check("period", n + 1, 32'd100);
        rate = 16'h0020;
        wait_tick(n);
        wait_tick(n);
        check("period short", n + 1, 32'd32);
    endtask
    // -----------------------------------------
    // verdict, reached from the main flow or the watchdog
    // -----------------------------------------
    task automatic close_out;
        $display("checks %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        repeat (20) @(posedge REF_CLK);
        check("reset pos", pos_s[31:0], 32'h0);
        check("reset tick", {31'h0, tick}, 32'h0);
        #1 RST = 1'b0;
        t_count();
        t_reverse();
        t_invert();
        t_fault();
        t_mark();
        t_rate();
        close_out();
    end
    // whole run is near 2000 cycles; cut it off well past that
    initial
    begin
        #200000;
        bad_count++;
        close_out();
    end
endmodule
